// ### hdl/m_of_n_window.v
// Sliding M-of-N window that qualifies threshold hits
`timescale 1ns/10ps
`include "prox_regs.vh"
module m_of_n_window (
    input wire core_clk_i,
    input wire resetn_i,
    input wire clr_i,
    input wire sample_i,
    input wire hit_i,
    input wire [3:0] m_i,
    input wire [3:0] n_i,
    output reg pass_o,
    output reg valid_o
);

reg [14:0] hist_q;
reg [14:0] hist_d;
reg [3:0] ones;
reg pass_d;
integer i;

// Count hits among the newest N results, including this one
always @* begin
    hist_d = {hist_q[13:0], hit_i};
    ones = 4'h0;
    for (i = 0; i < 15; i = i + 1) begin
        if ((i < n_i) && hist_d[i]) begin
            ones = ones + 4'h1;
        end
    end
    // Zero in M or N disables the interrupt
    pass_d = (m_i != 4'h0) && (n_i != 4'h0) && (ones >= m_i);
end

// History and result registers
always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        hist_q <= 15'h0000;
        pass_o <= 1'b0;
        valid_o <= 1'b0;
    end else if (clr_i) begin
        hist_q <= 15'h0000;
        pass_o <= 1'b0;
        valid_o <= 1'b0;
    end else begin
        valid_o <= sample_i;
        if (sample_i) begin
            hist_q <= hist_d;
            pass_o <= pass_d;
        end
    end
end

endmodule

// ### hdl/prox_cfg_irq.v
// Proximity sensor configuration registers, LED timing and interrupt logic
`timescale 1ns/10ps
`include "prox_regs.vh"

module prox_cfg_irq #(
    parameter [3:0] PART_CODE = 4'h3, // Arbitrary value
    parameter [3:0] REV_CODE = 4'h1 // Arbitrary value
) (
    input wire core_clk_i,
    input wire resetn_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    input wire stop_i,
    input wire meas_active_i,
    input wire meas_done_i,
    input wire [15:0] proximity_result_i,
    output reg [7:0] reg_rdata_o,
    output reg irq_pin_o,
    output reg soft_restart_o,
    output reg led_pulse_o,
    output reg sample_strobe_o,
    output reg led_drv_en_o,
    output reg [4:0] sink_current_code_o
);

// Register state
reg soft_restart_bit_q;
reg [2:0] irq_cfg_q;
reg [4:0] led_div_q;
reg [4:0] smp_dly_q;
reg [4:0] led_cur_q;
reg [7:0] up_hi_q;
reg [7:0] up_lo_q;
reg [7:0] lo_hi_q;
reg [7:0] lo_lo_q;
reg [7:0] filter_q;
reg [1:0] integ_q;

// Interrupt state
reg above_limit_flag_q;
reg below_limit_flag_q;
reg pin_state_q;
reg above_cap_q;
reg below_cap_q;
reg above_d;
reg below_d;
reg pin_d;

// LED timing state
reg [3:0] ref_cnt_q;
reg [4:0] phase_q;
reg led_on_q;
reg [7:0] dly_cnt_q;

// Soft reset fires when the bit is set and the transaction ends
wire srst = stop_i & soft_restart_bit_q;

// Mode decode
wire polarity = irq_cfg_q[`BIT_POLARITY];
wire self_release = irq_cfg_q[`BIT_SELF_RELEASE];
wire pulse_mode = irq_cfg_q[`BIT_PULSE_MODE];
wire hyst_on = integ_q[`BIT_HYST_EN - 4] & self_release;
wire trigger_side_select = integ_q[`BIT_TRIG_SIDE - 4];

// Limits assembled from MSB and LSB registers
wire [15:0] upper_limit = {up_hi_q, up_lo_q};
wire [15:0] lower_limit = {lo_hi_q, lo_lo_q};

// Unsigned window compare on each new result
wire above_c = proximity_result_i > upper_limit;
wire below_c = proximity_result_i < lower_limit;

// Which side feeds the filter: set side only under hysteresis
wire hit_c = hyst_on ? (trigger_side_select ? above_c : below_c)
                     : (above_c | below_c);

// Latched-mode read of the status register clears the flags
wire stat_rd = reg_rd_i && (reg_addr_i == `ADDR_IRQ_STAT);
wire rd_clr = stat_rd & ~self_release;

wire filt_pass;
wire filt_valid;

// M-of-N qualification of threshold hits
m_of_n_window u_window (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .clr_i(srst),
    .sample_i(meas_done_i),
    .hit_i(hit_c),
    .m_i(filter_q[`FILT_M_MSB:`FILT_M_LSB]),
    .n_i(filter_q[`FILT_N_MSB:`FILT_N_LSB]),
    .pass_o(filt_pass),
    .valid_o(filt_valid)
);

// Configuration registers, written over the register port
always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        soft_restart_bit_q <= `RST_SOFT_RST;
        irq_cfg_q <= `RST_IRQ_CFG;
        led_div_q <= `RST_LED_DIV;
        smp_dly_q <= `RST_SMP_DLY;
        led_cur_q <= `RST_LED_CUR;
        up_hi_q <= `RST_UP_LIM;
        up_lo_q <= `RST_UP_LIM;
        lo_hi_q <= `RST_LO_LIM;
        lo_lo_q <= `RST_LO_LIM;
        filter_q <= `RST_FILTER;
        integ_q <= `RST_INTEG;
    end else if (srst) begin
        soft_restart_bit_q <= `RST_SOFT_RST;
        irq_cfg_q <= `RST_IRQ_CFG;
        led_div_q <= `RST_LED_DIV;
        smp_dly_q <= `RST_SMP_DLY;
        led_cur_q <= `RST_LED_CUR;
        up_hi_q <= `RST_UP_LIM;
        up_lo_q <= `RST_UP_LIM;
        lo_hi_q <= `RST_LO_LIM;
        lo_lo_q <= `RST_LO_LIM;
        filter_q <= `RST_FILTER;
        integ_q <= `RST_INTEG;
    end else if (reg_wr_i) begin
        // Ident and status offsets take no write
        case (reg_addr_i)
            `ADDR_SOFT_RST: begin
                soft_restart_bit_q <= reg_wdata_i[`BIT_SOFT_RST];
            end
            `ADDR_IRQ_CFG: begin
                irq_cfg_q <= reg_wdata_i[2:0];
            end
            `ADDR_LED_DIV: begin
                led_div_q <= reg_wdata_i[4:0];
            end
            `ADDR_SMP_DLY: begin
                smp_dly_q <= reg_wdata_i[4:0];
            end
            `ADDR_LED_CUR: begin
                led_cur_q <= reg_wdata_i[4:0];
            end
            `ADDR_UP_HI: begin
                up_hi_q <= reg_wdata_i;
            end
            `ADDR_UP_LO: begin
                up_lo_q <= reg_wdata_i;
            end
            `ADDR_LO_HI: begin
                lo_hi_q <= reg_wdata_i;
            end
            `ADDR_LO_LO: begin
                lo_lo_q <= reg_wdata_i;
            end
            `ADDR_FILTER: begin
                filter_q <= reg_wdata_i;
            end
            `ADDR_INTEG: begin
                integ_q <= reg_wdata_i[5:4];
            end
            default: begin
                integ_q <= integ_q;
            end
        endcase
    end
end

// Read data, registered on each read strobe; unused bits read zero
always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
        case (reg_addr_i)
            `ADDR_IDENT: reg_rdata_o <= {PART_CODE, REV_CODE};
            `ADDR_SOFT_RST: reg_rdata_o <= {7'h00, soft_restart_bit_q};
            `ADDR_IRQ_CFG: reg_rdata_o <= {5'h00, irq_cfg_q};
            `ADDR_LED_DIV: reg_rdata_o <= {3'h0, led_div_q};
            `ADDR_SMP_DLY: reg_rdata_o <= {3'h0, smp_dly_q};
            `ADDR_LED_CUR: reg_rdata_o <= {3'h0, led_cur_q};
            `ADDR_UP_HI: reg_rdata_o <= up_hi_q;
            `ADDR_UP_LO: reg_rdata_o <= up_lo_q;
            `ADDR_LO_HI: reg_rdata_o <= lo_hi_q;
            `ADDR_LO_LO: reg_rdata_o <= lo_lo_q;
            `ADDR_FILTER: reg_rdata_o <= filter_q;
            `ADDR_INTEG: reg_rdata_o <= {2'h0, integ_q, 4'h0};
            `ADDR_IRQ_STAT: begin
                reg_rdata_o <= {3'h0, pin_state_q, 2'h0,
                                above_limit_flag_q,
                                below_limit_flag_q};
            end
            default: reg_rdata_o <= 8'h00;
        endcase
    end
end

// Next flag and pin values: status-read clear on any cycle, filter update when it answers
always @* begin
    above_d = rd_clr ? 1'b0 : above_limit_flag_q;
    below_d = rd_clr ? 1'b0 : below_limit_flag_q;
    if (filt_valid) begin
        if (!self_release) begin
            // Latched: new events add to what is pending
            above_d = above_d | (filt_pass & above_cap_q);
            below_d = below_d | (filt_pass & below_cap_q);
        end else if (hyst_on && trigger_side_select) begin
            if (filt_pass && above_cap_q) begin
                above_d = 1'b1;
            end else if (below_cap_q) begin
                above_d = 1'b0;
            end
            below_d = 1'b0;
        end else if (hyst_on) begin
            if (filt_pass && below_cap_q) begin
                below_d = 1'b1;
            end else if (above_cap_q) begin
                below_d = 1'b0;
            end
            above_d = 1'b0;
        end else begin
            // Self-release window mode: fresh decision every result
            above_d = filt_pass & above_cap_q;
            below_d = filt_pass & below_cap_q;
        end
    end
    if (pulse_mode) begin
        pin_d = filt_valid & (above_d | below_d);
    end else begin
        pin_d = above_d | below_d;
    end
end

// Interrupt flags, captured compare results and pin
always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        above_limit_flag_q <= 1'b0;
        below_limit_flag_q <= 1'b0;
        above_cap_q <= 1'b0;
        below_cap_q <= 1'b0;
        pin_state_q <= 1'b0;
        irq_pin_o <= 1'b1;
        soft_restart_o <= 1'b0;
    end else if (srst) begin
        above_limit_flag_q <= 1'b0;
        below_limit_flag_q <= 1'b0;
        above_cap_q <= 1'b0;
        below_cap_q <= 1'b0;
        pin_state_q <= 1'b0;
        irq_pin_o <= 1'b1;
        soft_restart_o <= 1'b1;
    end else begin
        soft_restart_o <= 1'b0;
        if (meas_done_i) begin
            above_cap_q <= above_c;
            below_cap_q <= below_c;
        end
        above_limit_flag_q <= above_d;
        below_limit_flag_q <= below_d;
        pin_state_q <= pin_d;
        irq_pin_o <= polarity ? pin_d : ~pin_d;
    end
end

// Effective divider, kept at the smallest valid value if set lower
wire [4:0] div_eff = (led_div_q < `MIN_LED_DIV) ? `MIN_LED_DIV
                                                : led_div_q;
// Timing counts held wide once, then cut to the counter widths
wire [31:0] tick_last = `REF_TICK_CYC - 1;
wire [31:0] step_cyc = `SAMPLE_STEP_CYC;
wire ref_tick = (ref_cnt_q == tick_last[3:0]);
wire [4:0] half_div = {1'b0, div_eff[4:1]};
wire led_run = meas_active_i & (led_cur_q != 5'h00);
wire led_on_d = led_run && (phase_q < half_div);
wire led_edge = led_on_d != led_on_q;
wire [7:0] dly_load = ({3'h0, smp_dly_q} - 8'h01) * step_cyc[7:0];

// 4 MHz reference tick and LED phase within one pulse period
always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        ref_cnt_q <= 4'h0;
        phase_q <= 5'h00;
        led_on_q <= 1'b0;
    end else if (srst || !led_run) begin
        ref_cnt_q <= 4'h0;
        phase_q <= 5'h00;
        led_on_q <= 1'b0;
    end else begin
        ref_cnt_q <= ref_tick ? 4'h0 : ref_cnt_q + 4'h1;
        if (ref_tick) begin
            // Period is div_eff reference ticks
            phase_q <= (phase_q >= div_eff - 5'h01) ? 5'h00
                                                    : phase_q + 5'h01;
        end
        led_on_q <= led_on_d;
    end
end

// Sample strobe a programmed delay after each LED edge
always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        dly_cnt_q <= 8'h00;
        sample_strobe_o <= 1'b0;
    end else if (srst) begin
        dly_cnt_q <= 8'h00;
        sample_strobe_o <= 1'b0;
    end else begin
        sample_strobe_o <= 1'b0;
        if (led_edge) begin
            if (smp_dly_q <= 5'h01) begin
                sample_strobe_o <= 1'b1;
                dly_cnt_q <= 8'h00;
            end else begin
                dly_cnt_q <= dly_load;
            end
        end else if (dly_cnt_q != 8'h00) begin
            dly_cnt_q <= dly_cnt_q - 8'h01;
            sample_strobe_o <= (dly_cnt_q == 8'h01);
        end
    end
end

// LED driver outputs: current code and enable
always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        led_pulse_o <= 1'b0;
        led_drv_en_o <= 1'b0;
        sink_current_code_o <= `RST_LED_CUR;
    end else begin
        led_pulse_o <= led_on_d;
        led_drv_en_o <= led_cur_q != 5'h00;
        sink_current_code_o <= led_cur_q;
    end
end

endmodule

// ### hdl/prox_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef PROX_REGS_VH
`define PROX_REGS_VH

// Register offsets (byte address on the serial register port)
`define ADDR_IDENT 8'h00
`define ADDR_SOFT_RST 8'h01
`define ADDR_IRQ_CFG 8'h02
`define ADDR_LED_DIV 8'h0D
`define ADDR_SMP_DLY 8'h0E
`define ADDR_LED_CUR 8'h0F
`define ADDR_UP_HI 8'h10
`define ADDR_UP_LO 8'h11
`define ADDR_LO_HI 8'h12
`define ADDR_LO_LO 8'h13
`define ADDR_FILTER 8'h14
`define ADDR_INTEG 8'h15
`define ADDR_IRQ_STAT 8'h40

// Reset values
`define RST_SOFT_RST 1'b0
`define RST_IRQ_CFG 3'h2
`define RST_LED_DIV 5'h10
`define RST_SMP_DLY 5'h05
`define RST_LED_CUR 5'h09
`define RST_UP_LIM 8'hFF
`define RST_LO_LIM 8'h00
`define RST_FILTER 8'h11
`define RST_INTEG 2'h0

// Field positions
`define BIT_SOFT_RST 0
`define BIT_POLARITY 0
`define BIT_SELF_RELEASE 1
`define BIT_PULSE_MODE 2
`define BIT_TRIG_SIDE 4
`define BIT_HYST_EN 5
`define BIT_STAT_BELOW 0
`define BIT_STAT_ABOVE 1
`define BIT_STAT_PIN 4
`define FILT_N_MSB 7
`define FILT_N_LSB 4
`define FILT_M_MSB 3
`define FILT_M_LSB 0

// Timing: core clock 40 MHz, internal LED reference 4 MHz
`define CORE_PERIOD_NS 25
`define CORE_CLK_KHZ 40000
`define REF_CLK_KHZ 4000
`define REF_TICK_CYC (`CORE_CLK_KHZ / `REF_CLK_KHZ)
`define SAMPLE_STEP_NS 125
`define SAMPLE_STEP_CYC ((`SAMPLE_STEP_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define MIN_LED_DIV 5'h02

`endif

// ### verif/host_model.sv
// Host model driving the register port of the sensor block
`timescale 1ns/10ps
module host_model (
    input wire core_clk_i,
    output reg [7:0] reg_addr_o,
    output reg reg_wr_o,
    output reg [7:0] reg_wdata_o,
    output reg reg_rd_o,
    output reg stop_o,
    input wire [7:0] reg_rdata_i
);
    // Idle port at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
        stop_o = 1'b0;
    end
    // Callers lower the delay before the divider and keep N >= M
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge core_clk_i);
            reg_addr_o <= a;
            reg_wdata_o <= d;
            reg_wr_o <= 1'b1;
            @(posedge core_clk_i);
            reg_wr_o <= 1'b0;
            reg_wdata_o <= ~d; // Released data does not hold its value
        end
    endtask
    // Read strobe, data taken one cycle after the taking edge
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge core_clk_i);
            reg_addr_o <= a;
            reg_rd_o <= 1'b1;
            @(posedge core_clk_i);
            reg_rd_o <= 1'b0;
            @(posedge core_clk_i);
            d = reg_rdata_i;
        end
    endtask
    // End of a serial transaction
    task stop;
        begin
            @(posedge core_clk_i);
            stop_o <= 1'b1;
            @(posedge core_clk_i);
            stop_o <= 1'b0;
        end
    endtask
endmodule

// ### verif/prox_cfg_irq_chk.sv
// Port-level checker for the proximity register and interrupt block
`timescale 1ns/10ps
module prox_cfg_irq_chk #(
    parameter [3:0] PART_CODE = 4'h3,
    parameter [3:0] REV_CODE = 4'h1
) (
    input wire core_clk_i,
    input wire resetn_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    input wire stop_i,
    input wire meas_done_i,
    input wire [7:0] reg_rdata_o,
    input wire irq_pin_o,
    input wire soft_restart_o,
    input wire sample_strobe_o,
    input wire led_drv_en_o,
    input wire [4:0] sink_current_code_o
);
    reg arm_q;
    reg [2:0] cfg_q;
    wire act_w = (irq_pin_o == cfg_q[0]);
    // Shadow of restart arming and pin style, so pin level can be judged
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            arm_q <= 1'b0;
            cfg_q <= 3'h2;
        end else if (arm_q && stop_i) begin
            arm_q <= 1'b0;
            cfg_q <= 3'h2;
        end else if (reg_wr_i && reg_addr_i == 8'h01) begin
            arm_q <= reg_wdata_i[0];
        end else if (reg_wr_i && reg_addr_i == 8'h02) begin
            cfg_q <= reg_wdata_i[2:0];
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence arm_stop_s;
        arm_q && stop_i;
    endsequence
    sequence status_rd_s;
        reg_rd_i && reg_addr_i == 8'h40;
    endsequence
    AST_RESTART: assert property (arm_stop_s |=> soft_restart_o)
        else $error("restart pulse missing");
    AST_RST_ONCE: assert property (soft_restart_o |=> !soft_restart_o)
        else $error("restart pulse too long");
    AST_DEFAULTS: assert property (soft_restart_o |-> ##[0:2]
        (sink_current_code_o == 5'h09 && led_drv_en_o && irq_pin_o))
        else $error("defaults not restored");
    AST_DRV_OFF: assert property (sink_current_code_o == 5'h00
        && $stable(sink_current_code_o) |-> !led_drv_en_o)
        else $error("driver on at zero code");
    AST_IDENT: assert property (reg_rd_i && reg_addr_i == 8'h00
        |=> reg_rdata_o == {PART_CODE, REV_CODE})
        else $error("ident value wrong");
    AST_PIN_STAT: assert property (status_rd_s ##0 !$past(reg_wr_i)
        && !$past(reg_wr_i, 2) |=> reg_rdata_o[4] == $past(act_w))
        else $error("status pin bit wrong");
    AST_PULSE: assert property (cfg_q[2] && act_w
        && !reg_wr_i |=> !act_w)
        else $error("pulse longer than one cycle");
    AST_MEAS_CAUSE: assert property ($rose(act_w) && !$past(reg_wr_i)
        && !$past(reg_wr_i, 2) |-> $past(meas_done_i, 2))
        else $error("pin asserted without measurement");
    AST_STROBE: assert property (sample_strobe_o |=> !sample_strobe_o)
        else $error("strobe longer than one cycle");
endmodule
bind prox_cfg_irq prox_cfg_irq_chk #(.PART_CODE(PART_CODE),
    .REV_CODE(REV_CODE)) u_chk (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i),
    .stop_i(stop_i),
    .meas_done_i(meas_done_i),
    .reg_rdata_o(reg_rdata_o),
    .irq_pin_o(irq_pin_o),
    .soft_restart_o(soft_restart_o),
    .sample_strobe_o(sample_strobe_o),
    .led_drv_en_o(led_drv_en_o),
    .sink_current_code_o(sink_current_code_o)
);

// ### verif/tb_prox_cfg_irq.sv
// Self-checking bench for the proximity register and interrupt block
`timescale 1ns/10ps
module tb_prox_cfg_irq;
    reg core_clk_i;
    reg resetn_i;
    reg meas_active_i;
    reg meas_done_i;
    reg [15:0] proximity_result_i;
    wire [7:0] reg_addr_i;
    wire reg_wr_i;
    wire [7:0] reg_wdata_i;
    wire reg_rd_i;
    wire stop_i;
    wire [7:0] reg_rdata_o;
    wire irq_pin_o;
    wire soft_restart_o;
    wire led_pulse_o;
    wire sample_strobe_o;
    wire led_drv_en_o;
    wire [4:0] sink_current_code_o;
    integer fails;
    integer tests_run;
    integer cnt;
    integer hcnt;
    integer i;
    reg [7:0] rd_v;
    // Register addresses with reset values, one unmapped place last
    localparam [103:0] DA = {8'h03, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11,
        8'h10, 8'h0F, 8'h0E, 8'h0D, 8'h02, 8'h01, 8'h00};
    localparam [103:0] DV = {8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'hFF,
        8'hFF, 8'h09, 8'h05, 8'h10, 8'h02, 8'h00, 8'h31};
    // Results and status for window, filter and hysteresis runs
    localparam [79:0] MR = {16'hF000, 16'h0100, 16'h00FF, 16'h1234,
        16'h1235};
    localparam [39:0] ME = {8'h12, 8'h00, 8'h11, 8'h00, 8'h12};
    localparam [95:0] FR = {16'h2000, 16'h0800, 16'h2000, 16'h0800,
        16'h0800, 16'h0800};
    localparam [47:0] FE = {8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam [95:0] HR = {16'h2000, 16'h0800, 16'h0050, 16'h0050,
        16'h0800, 16'h2000};
    localparam [47:0] HE = {8'h00, 8'h11, 8'h11, 8'h00, 8'h12, 8'h12};

    prox_cfg_irq #(.PART_CODE(4'h3), .REV_CODE(4'h1)) dut ( // Arbitrary ids
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i),
        .stop_i(stop_i),
        .meas_active_i(meas_active_i),
        .meas_done_i(meas_done_i),
        .proximity_result_i(proximity_result_i),
        .reg_rdata_o(reg_rdata_o),
        .irq_pin_o(irq_pin_o),
        .soft_restart_o(soft_restart_o),
        .led_pulse_o(led_pulse_o),
        .sample_strobe_o(sample_strobe_o),
        .led_drv_en_o(led_drv_en_o),
        .sink_current_code_o(sink_current_code_o)
    );
    host_model host (
        .core_clk_i(core_clk_i),
        .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i),
        .reg_rd_o(reg_rd_i),
        .stop_o(stop_i),
        .reg_rdata_i(reg_rdata_o)
    );
    // 40 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    task tick;
        begin
            @(posedge core_clk_i);
            #1;
        end
    endtask
    task print_verdict;
        begin
            $display("counts fails=%0d tests_run=%0d", fails, tests_run);
            if (fails == 0 && tests_run > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task rchk(input [7:0] a, input [7:0] exp);
        begin
            host.rd(a, rd_v);
            chk(rd_v, exp);
        end
    endtask
    // One measurement, counting cycles with the pin high meanwhile
    task ms(input [15:0] r, input [7:0] exp, input rd_it);
        begin
            @(posedge core_clk_i);
            meas_done_i <= 1'b1;
            proximity_result_i <= r;
            @(posedge core_clk_i);
            meas_done_i <= 1'b0;
            proximity_result_i <= ~r;
            repeat (4) begin
                tick;
                if (irq_pin_o === 1'b1) hcnt = hcnt + 1;
            end
            if (rd_it) rchk(8'h40, exp);
        end
    endtask
    // Bounded wait for LED or strobe level, cycles left in cnt
    task wait_sig(input sel, input v);
        begin
            cnt = 0;
            while ((sel ? sample_strobe_o : led_pulse_o) !== v) begin
                tick;
                cnt = cnt + 1;
                if (cnt > 500) begin
                    fails = fails + 1;
                    print_verdict;
                end
            end
        end
    endtask
    task led(input [7:0] per, input [7:0] dly);
        integer p;
        begin
            repeat (2) begin
                wait_sig(1'b0, 1'b0);
                wait_sig(1'b0, 1'b1);
            end
            wait_sig(1'b1, 1'b1);
            chk(cnt[7:0], dly);
            p = cnt;
            wait_sig(1'b0, 1'b0);
            p = p + cnt;
            wait_sig(1'b0, 1'b1);
            p = p + cnt;
            chk(p[7:0], per);
        end
    endtask
    task defaults;
        for (i = 0; i < 13; i = i + 1)
            rchk(DA[i*8 +: 8], DV[i*8 +: 8]);
    endtask
    initial begin
        fails = 0;
        tests_run = 0;
        hcnt = 0;
        resetn_i = 1'b0;
        meas_active_i = 1'b0;
        meas_done_i = 1'b0;
        proximity_result_i = 16'h0000;
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        tick;
        chk({7'h00, irq_pin_o}, 8'h01);
        defaults;
        host.wr(8'h00, 8'hA5);
        rchk(8'h00, 8'h31);
        $display("test reset done");
        host.wr(8'h0F, 8'h00);
        repeat (2) tick;
        chk({7'h00, led_drv_en_o}, 8'h00);
        host.wr(8'h0F, 8'h1F);
        repeat (2) tick;
        chk({3'h0, sink_current_code_o}, 8'h1F);
        chk({7'h00, led_drv_en_o}, 8'h01);
        $display("test current done");
        host.wr(8'h10, 8'h12);
        host.wr(8'h11, 8'h34);
        host.wr(8'h12, 8'h01);
        host.wr(8'h13, 8'h00);
        for (i = 0; i < 5; i = i + 1)
            ms(MR[i*16 +: 16], ME[i*8 +: 8], 1'b1);
        host.wr(8'h14, 8'h32);
        for (i = 0; i < 6; i = i + 1)
            ms(FR[i*16 +: 16], FE[i*8 +: 8], 1'b1);
        host.wr(8'h14, 8'h30);
        ms(16'h2000, 8'h00, 1'b1);
        host.wr(8'h14, 8'h11);
        $display("test window done");
        host.wr(8'h15, 8'h30);
        for (i = 0; i < 6; i = i + 1) begin
            if (i == 3) host.wr(8'h15, 8'h20);
            ms(HR[i*16 +: 16], HE[i*8 +: 8], 1'b1);
        end
        $display("test hysteresis done");
        host.wr(8'h02, 8'h00);
        ms(16'h2000, 8'h00, 1'b0);
        ms(16'h0800, 8'h00, 1'b0);
        chk({7'h00, irq_pin_o}, 8'h00);
        rchk(8'h40, 8'h12);
        rchk(8'h40, 8'h00);
        chk({7'h00, irq_pin_o}, 8'h01);
        $display("test latched done");
        host.wr(8'h15, 8'h00);
        host.wr(8'h02, 8'h07);
        hcnt = 0;
        ms(16'h2000, 8'h00, 1'b0);
        chk(hcnt[7:0], 8'h01);
        host.wr(8'h02, 8'h03);
        repeat (2) tick;
        chk({7'h00, irq_pin_o}, 8'h01);
        ms(16'h0800, 8'h00, 1'b1);
        chk({7'h00, irq_pin_o}, 8'h00);
        $display("test pin style done");
        @(posedge core_clk_i);
        meas_active_i <= 1'b1;
        led(8'hA0, 8'h14);
        host.wr(8'h0E, 8'h03);
        host.wr(8'h0D, 8'h04);
        led(8'h28, 8'h0A);
        host.wr(8'h0E, 8'h01);
        host.wr(8'h0D, 8'h02);
        led(8'h14, 8'h00);
        @(posedge core_clk_i);
        meas_active_i <= 1'b0;
        $display("test led done");
        host.wr(8'h01, 8'h01);
        host.stop;
        #1;
        chk({7'h00, soft_restart_o}, 8'h01);
        defaults;
        $display("test soft reset done");
        print_verdict;
    end
endmodule
